/* design/drf_regs.vh */
// Constants for the dual-read register file of the bit slice.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef DRF_REGS_VH
`define DRF_REGS_VH
// ----------------------------------------
// Operand source select codes
// ----------------------------------------
`define DRF_SRC_REG   2'h0
`define DRF_SRC_DIN   2'h1
`define DRF_SRC_HOLD  2'h2
// ----------------------------------------
// Result destination codes
// ----------------------------------------
`define DRF_DST_NONE  2'h0
`define DRF_DST_REGA  2'h1
`define DRF_DST_REGB  2'h2
`define DRF_DST_HOLD  2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DRF_HOLD_RST  4'h0
`define DRF_OUT_RST   4'h0
`endif

/* design/drf_operand_latch.v */
// Level-sensitive operand latch, transparent while the gate is high.
// Assumes the gate is the slice clock input and data settles before it falls.
`default_nettype none
module drf_operand_latch #(
   parameter WIDTH = 4
) (
   input  wire             gate,
   input  wire [WIDTH-1:0] dIn,
   output reg  [WIDTH-1:0] qOut
);
   // ----------------------------------------
   // Latch
   // ----------------------------------------
   always @* begin
      if (gate) begin
         qOut = dIn;
      end else begin
         qOut = qOut;
      end
   end
endmodule
`default_nettype wire

/* design/drf_register_file.v */
// Dual-read register file of a four-bit slice with operand latches and muxes.
// Assumes the ALU sits outside: it sees aluOpA/aluOpB and returns aluResult.
`include "drf_regs.vh"
`default_nettype none
module drf_register_file #(
   parameter WIDTH = 4,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire             clock_pulse_in,
   input  wire [AW-1:0]    addrA,
   input  wire [AW-1:0]    addrB,
   input  wire [1:0]       srcSelA,
   input  wire [1:0]       srcSelB,
   input  wire [WIDTH-1:0] dataIn,
   input  wire [WIDTH-1:0] aluResult,
   input  wire [1:0]       dstSel,
   output wire [WIDTH-1:0] aluOpA,
   output wire [WIDTH-1:0] aluOpB,
   output wire [WIDTH-1:0] rawA,
   output wire [WIDTH-1:0] rawB,
   output reg  [WIDTH-1:0] holdReg_r,
   output reg  [WIDTH-1:0] resultOut_r
);
   // ----------------------------------------
   // Clock-phase input synchroniser
   // ----------------------------------------
   // The phase pin is foreign to clk_sys, so it passes two flops first.
   reg         phaseMeta_r;
   reg         phaseSync_r;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         phaseMeta_r <= 1'b0;
         phaseSync_r <= 1'b0;
      end else begin
         phaseMeta_r <= clock_pulse_in;
         phaseSync_r <= phaseMeta_r;
      end
   end

   // ----------------------------------------
   // Register array
   // ----------------------------------------
   // No reset on the array: contents are undefined until written.
   reg  [WIDTH-1:0] regArray [0:DEPTH-1];
   wire [WIDTH-1:0] readA;
   wire [WIDTH-1:0] readB;
   assign readA = regArray[addrA];
   assign readB = regArray[addrB];

   // ----------------------------------------
   // Operand latches
   // ----------------------------------------
   // Modelled as sampling flops gated by the synchronised phase, so every
   // register stays on clk_sys; the trade is two cycles of phase delay.
   reg  [WIDTH-1:0] latchA_r;
   reg  [WIDTH-1:0] latchB_r;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latchA_r <= `DRF_OUT_RST;
         latchB_r <= `DRF_OUT_RST;
      end else if (phaseSync_r) begin
         latchA_r <= readA;
         latchB_r <= readB;
      end
   end
   // Low phase: latches hold, so the fed-back result stays stable.
   assign rawA = latchA_r;
   assign rawB = latchB_r;

   // ----------------------------------------
   // Operand multiplexers
   // ----------------------------------------
   reg  [WIDTH-1:0] opA;
   reg  [WIDTH-1:0] opB;
   always @* begin
      if (srcSelA == `DRF_SRC_DIN) begin
         opA = dataIn;
      end else if (srcSelA == `DRF_SRC_HOLD) begin
         opA = holdReg_r;
      end else begin
         opA = latchA_r;
      end
   end
   always @* begin
      if (srcSelB == `DRF_SRC_DIN) begin
         opB = dataIn;
      end else if (srcSelB == `DRF_SRC_HOLD) begin
         opB = holdReg_r;
      end else begin
         opB = latchB_r;
      end
   end
   assign aluOpA = opA;
   assign aluOpB = opB;

   // ----------------------------------------
   // Write-back, one per low phase
   // ----------------------------------------
   // A write fires on the first cycle of the low phase only, so a long low
   // phase cannot write twice.
   reg  phaseLow_r;
   wire writeSlot;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         // Start as if already low, so leaving reset opens no write slot
         phaseLow_r <= 1'b1;
      end else begin
         phaseLow_r <= !phaseSync_r;
      end
   end
   assign writeSlot = !phaseSync_r && !phaseLow_r;

   wire [AW-1:0] writeAddr;
   wire          writeEn;
   assign writeAddr = (dstSel == `DRF_DST_REGB) ? addrB : addrA;
   assign writeEn   = writeSlot &&
                      ((dstSel == `DRF_DST_REGA) || (dstSel == `DRF_DST_REGB));

   always @(posedge clk_sys) begin
      if (writeEn) begin
         regArray[writeAddr] <= aluResult;
      end
   end

   // ----------------------------------------
   // Holding register and off-chip output
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         holdReg_r   <= `DRF_HOLD_RST;
         resultOut_r <= `DRF_OUT_RST;
      end else begin
         resultOut_r <= aluResult;
         if (writeSlot && (dstSel == `DRF_DST_HOLD)) begin
            holdReg_r <= aluResult;
         end
      end
   end

   // ----------------------------------------
   // Raw latch view
   // ----------------------------------------
   // Raw latch taps are exported so the slice can observe operands directly;
   // the pure-latch cell drf_operand_latch remains available for async use.
   drf_operand_latch #(
      .WIDTH (WIDTH)
   ) unusedLatch (
      .gate (1'b0),
      .dIn  ({WIDTH{1'b0}}),
      .qOut ()
   );
endmodule
`default_nettype wire

/* bench/drf_alu_model.sv */
// Far-side ALU model: exclusive OR of the two operands.
// Assumes operands come straight from the register file muxes.
`default_nettype none
module drf_alu_model (
   input  wire logic [3:0] opA,
   input  wire logic [3:0] opB,
   output logic      [3:0] res
);
   timeunit 1ns;
   timeprecision 100ps;
   // XOR lets a pass-through and a self-clear share one fixed function
   assign res = opA ^ opB;
endmodule
`default_nettype wire

/* bench/drf_chk_asserts.sv */
// Port checker for the dual-read register file.
// Assumes the bind below attaches it to every instance.
`default_nettype none
module drf_chk (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       clock_pulse_in,
   input wire logic [3:0] addrA,
   input wire logic [3:0] addrB,
   input wire logic [1:0] srcSelA,
   input wire logic [1:0] srcSelB,
   input wire logic [3:0] dataIn,
   input wire logic [3:0] aluResult,
   input wire logic [1:0] dstSel,
   input wire logic [3:0] aluOpA,
   input wire logic [3:0] aluOpB,
   input wire logic [3:0] rawA,
   input wire logic [3:0] rawB,
   input wire logic [3:0] holdReg_r,
   input wire logic [3:0] resultOut_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   muxA_a: assert property (aluOpA == (srcSelA == 2'h1 ? dataIn :
      srcSelA == 2'h2 ? holdReg_r : rawA)) else $error("operand A mux wrong");
   muxB_a: assert property (aluOpB == (srcSelB == 2'h1 ? dataIn :
      srcSelB == 2'h2 ? holdReg_r : rawB)) else $error("operand B mux wrong");
   latch_hold_a: assert property (!clock_pulse_in [*5] |=>
      $stable(rawA) && $stable(rawB)) else $error("latch moved in low phase");
   same_addr_a: assert property (!clock_pulse_in ##1
      (clock_pulse_in && addrA == addrB) [*6]
      |-> rawA == rawB) else $error("equal addresses differ");
   high_nowrite_a: assert property (clock_pulse_in [*5] |=> $stable(holdReg_r))
      else $error("write in high phase");
   hold_load_a: assert property ($changed(holdReg_r) |->
      holdReg_r == $past(aluResult) && $past(dstSel) == 2'h3) else $error("bad hold write");
   one_write_a: assert property ($changed(holdReg_r) |=> $stable(holdReg_r) [*3])
      else $error("second write in phase");
   out_reg_a: assert property (1'b1 |=> resultOut_r == $past(aluResult))
      else $error("result output lags");
   cover property ($changed(holdReg_r));
   cover property (clock_pulse_in && addrA == addrB);
   cover property ($fell(clock_pulse_in) && dstSel == 2'h1);
endmodule
bind drf_register_file drf_chk chk_u (.*);
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the register file, XOR ALU on the far side.
// Assumes the ALU model and the bound checker compile before it.
`include "drf_regs.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys = 0, reset_n = 0, cpi = 0, chk = 0;
   logic [3:0]  aA = 0, aB = 0, din = 0, opA, opB, res, rawA, rawB, hreg;
   logic [3:0]  hold = `DRF_HOLD_RST;
   logic [1:0]  sA = 0, sB = 0, dst = 0;
   logic [3:0]  mem [16];
   logic [11:0] q [$];
   logic [11:0] e;
   logic [18:0] v;
   int          miscompares = 0, checks_done = 0, cyc = 0;
   always #12.5 clk_sys = ~clk_sys;
   drf_register_file dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clock_pulse_in(cpi),
      .addrA(aA), .addrB(aB), .srcSelA(sA), .srcSelB(sB), .dataIn(din), .aluResult(res),
      .dstSel(dst), .aluOpA(opA), .aluOpB(opB), .rawA(rawA), .rawB(rawB),
      .holdReg_r(hreg), .resultOut_r());
   drf_alu_model alu_u (.opA(opA), .opB(opB), .res(res));
   function automatic logic [3:0] src(logic [1:0] s, logic [3:0] d, m);
      return s == 2'h1 ? d : s == 2'h2 ? hold : m;
   endfunction
   // Latches must still show the contents from before this phase's write
   task automatic ph(input logic [3:0] a, b, d, input logic [1:0] s1, s2, t, input bit c);
      logic [3:0] r;
      @(negedge clk_sys);
      {aA, aB, din, sA, sB, dst, cpi} = {a, b, d, s1, s2, t, 1'b1};
      r = src(s1, d, mem[a]) ^ src(s2, d, mem[b]);
      if (c) q.push_back({mem[a], mem[b], t == 2'h3 ? r : hold});
      if (t == 2'h1) mem[a] = r;
      if (t == 2'h2) mem[b] = r;
      if (t == 2'h3) hold = r;
      repeat (6) @(negedge clk_sys);
      cpi = 0;
      repeat (6) @(negedge clk_sys);
      chk = c;
      @(negedge clk_sys);
      chk = 0;
   endtask
   always @(posedge clk_sys) if (chk) begin
      e = q.pop_front();
      checks_done++;
      if ({rawA, rawB, hreg} !== e) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, {rawA, rawB, hreg}, e);
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 1000) begin
         miscompares++;
         test_done;
      end
   end
   initial begin
      void'($urandom(78));
      repeat (3) @(negedge clk_sys);
      reset_n = 1;
      for (int i = 0; i < 16; i++) ph(4'(i), 4'(15 - i), 4'($urandom), 2'h1, 2'h2, 2'h1, 0);
      $display("test fill done");
      for (int i = 0; i < 24; i++) begin
         v = 19'($urandom);
         ph(v[3:0], v[7:4], v[11:8], v[13:12], v[15:14], v[17:16], 1);
      end
      $display("test random done");
      ph(4'h5, 4'h5, 4'h0, 2'h0, 2'h0, 2'h2, 1);
      ph(4'h5, 4'h5, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      $display("test same address done");
      test_done;
   end
endmodule
`default_nettype wire
